// ==== src/flash_bus_mode_control.sv ====
// host-side controller that drives the flash memory bus pins
`timescale 1ns/100ps
`default_nettype none
module flash_bus_mode_control
   import flash_host_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // user request port
   input wire logic i_req,
   input wire logic [1:0] i_op,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_cmd,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_powerdown,
   output logic o_ready,
   output logic o_done,
   output logic [DATA_W-1:0] o_rdata,
   output logic o_flash_busy,
   // flash pins
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n,
   output logic o_powerdown_reset_n,
   output logic [ADDR_W-1:0] o_addr,
   output logic [DATA_W-1:0] o_dq_out,
   output logic o_dq_oe,
   input wire logic [DATA_W-1:0] i_dq_in,
   input wire logic i_ready_busy_n,
   output logic o_vpp_enable
);

   // ==========================================================
   // state
   typedef enum logic [2:0] {
      ST_PD,
      ST_IDLE,
      ST_RD,
      ST_WR_SETUP,
      ST_WR_PULSE,
      ST_WR_HOLD,
      ST_WR_GAP
   } state_t;

   state_t state_reg, state_next;
   logic ce_reg, ce_next, oe_reg, oe_next, we_reg, we_next;
   logic pd_reg, pd_next, dq_oe_reg, dq_oe_next;
   logic vpp_reg, vpp_next, done_reg, done_next;
   logic ready_reg, ready_next, busy_reg, busy_next;
   logic two_step_reg, two_step_next, second_reg, second_next;
   logic abort_reg, abort_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [DATA_W-1:0] dq_reg, dq_next, wdata_reg, wdata_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic [CNT_W-1:0] wake_cnt_reg, wake_cnt_next;
   logic [CNT_W-1:0] tmr_count;
   logic tmr_load, tmr_zero;

   flash_phase_timer #(
      .RESET_COUNT(PD_HOLD_CYC)
   ) u_timer (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_load(tmr_load),
      .i_count(tmr_count),
      .o_zero(tmr_zero)
   );

   // ==========================================================
   // wake interval counter, restarts while power-down is low
   always_comb begin
      wake_cnt_next = wake_cnt_reg;
      if (!pd_reg) begin
         wake_cnt_next = CNT_ZERO;
      end else if (wake_cnt_reg < WAKE_TO_WRITE_CYC) begin
         wake_cnt_next = wake_cnt_reg + CNT_ONE;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         wake_cnt_reg <= CNT_ZERO;
      end else begin
         wake_cnt_reg <= wake_cnt_next;
      end
   end

   // ==========================================================
   // bus sequencer
   always_comb begin
      state_next = state_reg;
      ce_next = ce_reg;
      oe_next = oe_reg;
      we_next = we_reg;
      pd_next = pd_reg;
      dq_oe_next = dq_oe_reg;
      dq_next = dq_reg;
      vpp_next = vpp_reg;
      two_step_next = two_step_reg;
      second_next = second_reg;
      abort_next = abort_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      done_next = 1'b0;
      busy_next = !i_ready_busy_n;
      tmr_load = 1'b0;
      tmr_count = CNT_ZERO;
      case (state_reg)
         ST_PD: begin
            pd_next = 1'b0;
            if (tmr_zero && !i_powerdown) begin
               pd_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (i_powerdown) begin
               // a busy device is aborted; ready then waits the longer write interval for any request
               abort_next = !i_ready_busy_n;
               vpp_next = 1'b0;
               pd_next = 1'b0;
               tmr_load = 1'b1;
               tmr_count = PD_HOLD_CYC;
               state_next = ST_PD;
            end else if (i_req && ready_reg) begin
               addr_next = i_addr;
               wdata_next = i_wdata;
               ce_next = 1'b0;
               if (op_t'(i_op) == OP_READ) begin
                  oe_next = 1'b0;
                  tmr_load = 1'b1;
                  tmr_count = READ_ACCESS_CYC;
                  state_next = ST_RD;
               end else begin
                  two_step_next = (op_t'(i_op) == OP_TWO_STEP);
                  vpp_next = (op_t'(i_op) == OP_TWO_STEP);
                  second_next = 1'b0;
                  dq_oe_next = 1'b1;
                  dq_next = (op_t'(i_op) == OP_TWO_STEP) ? i_cmd : i_wdata;
                  state_next = ST_WR_SETUP;
               end
            end
         end
         ST_RD: begin
            if (tmr_zero) begin
               rdata_next = i_dq_in;
               ce_next = 1'b1;
               oe_next = 1'b1;
               done_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_WR_SETUP: begin
            we_next = 1'b0;
            tmr_load = 1'b1;
            tmr_count = WE_PULSE_CYC;
            state_next = ST_WR_PULSE;
         end
         ST_WR_PULSE: begin
            if (tmr_zero) begin
               we_next = 1'b1;
               state_next = ST_WR_HOLD;
            end
         end
         ST_WR_HOLD: begin
            ce_next = 1'b1;
            dq_oe_next = 1'b0;
            state_next = ST_WR_GAP;
         end
         ST_WR_GAP: begin
            if (two_step_reg && !second_reg) begin
               second_next = 1'b1;
               ce_next = 1'b0;
               dq_oe_next = 1'b1;
               dq_next = wdata_reg;
               state_next = ST_WR_SETUP;
            end else begin
               done_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_PD;
         end
      endcase
      ready_next = (state_next == ST_IDLE) && !i_powerdown && pd_next &&
         (wake_cnt_next >= (abort_next ? WAKE_TO_WRITE_CYC :
          WAKE_TO_OUTPUT_CYC));
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_reg <= ST_PD;
         ce_reg <= 1'b1;
         oe_reg <= 1'b1;
         we_reg <= 1'b1;
         pd_reg <= 1'b0;
         dq_oe_reg <= 1'b0;
         dq_reg <= DATA_ZERO;
         vpp_reg <= 1'b0;
         two_step_reg <= 1'b0;
         second_reg <= 1'b0;
         abort_reg <= 1'b0;
         addr_reg <= ADDR_ZERO;
         wdata_reg <= DATA_ZERO;
         rdata_reg <= DATA_ZERO;
         done_reg <= 1'b0;
         ready_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ce_reg <= ce_next;
         oe_reg <= oe_next;
         we_reg <= we_next;
         pd_reg <= pd_next;
         dq_oe_reg <= dq_oe_next;
         dq_reg <= dq_next;
         vpp_reg <= vpp_next;
         two_step_reg <= two_step_next;
         second_reg <= second_next;
         abort_reg <= abort_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         rdata_reg <= rdata_next;
         done_reg <= done_next;
         ready_reg <= ready_next;
         busy_reg <= busy_next;
      end
   end

   assign o_ce_n = ce_reg;
   assign o_oe_n = oe_reg;
   assign o_we_n = we_reg;
   assign o_powerdown_reset_n = pd_reg;
   assign o_addr = addr_reg;
   assign o_dq_out = dq_reg;
   assign o_dq_oe = dq_oe_reg;
   assign o_vpp_enable = vpp_reg;
   assign o_rdata = rdata_reg;
   assign o_done = done_reg;
   assign o_ready = ready_reg;
   assign o_flash_busy = busy_reg;

   // ==========================================================
   // assertions
   a_read_strobes: assert property (@(posedge i_clk) disable iff (i_reset)
      !oe_reg |-> !ce_reg && we_reg && pd_reg)
      else $error("read strobes not in read pattern");
   a_write_oe_high: assert property (@(posedge i_clk) disable iff (i_reset)
      !we_reg |-> oe_reg && dq_oe_reg && !ce_reg)
      else $error("output enable low or data idle during write");
   a_pd_hold_time: assert property (@(posedge i_clk) disable iff (i_reset)
      $fell(pd_reg) |-> !pd_reg [*3])
      else $error("power-down released too early");
   a_wake_read: assert property (@(posedge i_clk) disable iff (i_reset)
      $fell(oe_reg) |-> wake_cnt_reg >= WAKE_TO_OUTPUT_CYC)
      else $error("read started before wake interval");
   a_abort_write: assert property (@(posedge i_clk) disable iff (i_reset)
      $fell(we_reg) && abort_reg |->
      wake_cnt_reg >= WAKE_TO_WRITE_CYC)
      else $error("write issued too soon after abort");
   a_reset_pd: assert property (@(posedge i_clk)
      i_reset |=> !pd_reg)
      else $error("power-down not low after system reset");
   a_vpp_program: assert property (@(posedge i_clk) disable iff (i_reset)
      !we_reg && two_step_reg |-> vpp_reg)
      else $error("programming supply off during two-step write");
   a_addr_stable: assert property (@(posedge i_clk) disable iff (i_reset)
      !we_reg |-> $stable(addr_reg) && $stable(dq_reg))
      else $error("address or data moved during write pulse");
   a_two_step_pair: assert property (@(posedge i_clk) disable iff (i_reset)
      $rose(we_reg) && two_step_reg && !second_reg |->
      ##[3:8] (!we_reg && second_reg && dq_reg == wdata_reg))
      else $error("second step of command pair missing");

   c_read_done: cover property (@(posedge i_clk) disable iff (i_reset)
      done_reg && two_step_reg == 1'b0 && $past(state_reg) == ST_RD);
   c_two_step_done: cover property (@(posedge i_clk) disable iff (i_reset)
      done_reg && two_step_reg && second_reg);
   c_abort: cover property (@(posedge i_clk) disable iff (i_reset)
      $fell(pd_reg) ##1 abort_reg);

endmodule
`default_nettype wire

// ==== src/flash_host_pkg.sv ====
// constants and types shared by the flash bus mode controller
package flash_host_pkg;

   // ==========================================================
   // widths
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int CNT_W = 8;

   // ==========================================================
   // clock and bus timing, in nanoseconds as specified
   localparam int CLK_PERIOD_NS = 40;
   localparam int PD_HOLD_NS = 100;
   localparam int READ_ACCESS_NS = 90;
   localparam int WE_PULSE_NS = 50;
   localparam int WAKE_TO_OUTPUT_NS = 600;
   localparam int WAKE_TO_WRITE_NS = 1000;

   // ==========================================================
   // derived cycle counts; least times round up
   localparam logic [CNT_W-1:0] PD_HOLD_CYC =
      CNT_W'((PD_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] READ_ACCESS_CYC =
      CNT_W'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WE_PULSE_CYC =
      CNT_W'((WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WAKE_TO_OUTPUT_CYC =
      CNT_W'((WAKE_TO_OUTPUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WAKE_TO_WRITE_CYC =
      CNT_W'((WAKE_TO_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ==========================================================
   // reset values and counter step
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 20'h00000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

   // ==========================================================
   // user operations
   typedef enum logic [1:0] {
      OP_READ,
      OP_WRITE,
      OP_TWO_STEP,
      OP_SPARE
   } op_t;

endpackage

// ==== src/flash_phase_timer.sv ====
// down counter that times one bus phase
`timescale 1ns/100ps
`default_nettype none
module flash_phase_timer
   import flash_host_pkg::*;
#(
   parameter logic [CNT_W-1:0] RESET_COUNT = CNT_ZERO
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // control
   input wire logic i_load,
   input wire logic [CNT_W-1:0] i_count,
   // status
   output logic o_zero
);

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;

   always_comb begin
      cnt_next = cnt_reg;
      if (i_load) begin
         cnt_next = i_count;
      end else if (cnt_reg != CNT_ZERO) begin
         cnt_next = cnt_reg - CNT_ONE;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cnt_reg <= RESET_COUNT;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign o_zero = (cnt_reg == CNT_ZERO);

endmodule
`default_nettype wire

// ==== tb/flash_bus_mode_control_tb.sv ====
// self-checking bench for the flash bus mode controller
`timescale 1ns/100ps
`default_nettype none
module flash_bus_mode_control_tb;
   import flash_host_pkg::*;
   localparam logic [15:0] MAKER = 16'h00A5; // arbitrary value
   localparam logic [15:0] PART = 16'h005A; // arbitrary value
   logic i_clk, i_reset, i_req, i_powerdown;
   logic [1:0] i_op;
   logic [19:0] i_addr, o_addr;
   logic [15:0] i_cmd, i_wdata, o_rdata, o_dq_out, dq_in;
   logic o_ready, o_done, o_flash_busy, o_ce_n, o_oe_n, o_we_n;
   logic pd_n, o_dq_oe, rb_n, o_vpp_enable;
   int err_count, samples_checked;
   flash_bus_mode_control uut (.i_clk(i_clk), .i_reset(i_reset),
      .i_req(i_req), .i_op(i_op), .i_addr(i_addr), .i_cmd(i_cmd),
      .i_wdata(i_wdata), .i_powerdown(i_powerdown), .o_ready(o_ready),
      .o_done(o_done), .o_rdata(o_rdata), .o_flash_busy(o_flash_busy),
      .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
      .o_powerdown_reset_n(pd_n), .o_addr(o_addr), .o_dq_out(o_dq_out),
      .o_dq_oe(o_dq_oe), .i_dq_in(dq_in), .i_ready_busy_n(rb_n),
      .o_vpp_enable(o_vpp_enable));
   flash_dev_model #(.MAKER(MAKER), .PART(PART)) dev (.i_clk(i_clk),
      .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_pd_n(pd_n),
      .i_vpp(o_vpp_enable), .i_addr(o_addr), .i_dq_out(o_dq_out),
      .i_dq_oe(o_dq_oe), .o_dq(dq_in), .o_ready_busy_n(rb_n));
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   // ==========================================================
   // shared tasks
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic hang(input string nm);
      err_count++;
      $display("mismatch %s expected event seen timeout", nm);
      tally_and_finish();
   endtask
   task automatic req(input logic [1:0] op, input logic [19:0] a,
      input logic [15:0] c, w);
      int n;
      n = 0;
      while (o_ready !== 1'b1) begin
         @(negedge i_clk);
         n++;
         if (n > 60) hang("ready");
      end
      i_req = 1'b1;
      i_op = op;
      i_addr = a;
      i_cmd = c;
      i_wdata = w;
      @(negedge i_clk);
      i_req = 1'b0;
      n = 0;
      while (o_done !== 1'b1) begin
         @(negedge i_clk);
         n++;
         if (n > 30) hang("done");
      end
      chk("idle_pins", 16'h000E, {12'h000, o_ce_n, o_oe_n, o_we_n,
         o_dq_oe});
   endtask
   task automatic rd(input string nm, input logic [19:0] a,
      input logic [15:0] e);
      req(2'h0, a, 16'h0000, 16'h0000);
      chk(nm, e, o_rdata);
   endtask
   task automatic wake(input int min);
      int n;
      int t;
      n = 0;
      t = 0;
      while (pd_n !== 1'b1 || o_ready !== 1'b1) begin
         @(negedge i_clk);
         t++;
         if (pd_n === 1'b1) n++;
         if (t > 80) hang("wake");
      end
      chk("wake_wait", 16'h0001, 16'(n >= min));
   endtask
   task automatic busy_run();
      int n;
      n = 0;
      while (o_flash_busy !== 1'b1) begin
         @(negedge i_clk);
         n++;
         if (n > 10) hang("busy");
      end
   endtask
   // ==========================================================
   // scenarios
   task automatic t_program();
      req(2'h2, 20'h00010, 16'h0040, 16'h1234);
      chk("vpp", 16'h0001, {15'h0, o_vpp_enable});
      busy_run();
      repeat (40) @(negedge i_clk);
      chk("busy_end", 16'h0000, {15'h0, o_flash_busy});
      req(2'h1, 20'h00010, 16'h0000, 16'h00FF);
      rd("prog_data", 20'h00010, 16'h1234);
   endtask
   task automatic t_one_step();
      // spare op code must act as a single write
      req(2'h3, 20'h00011, 16'h0000, 16'h5678);
      rd("one_step", 20'h00011, 16'hFFFF);
   endtask
   task automatic t_ident();
      req(2'h1, 20'h00000, 16'h0000, 16'h0090);
      rd("maker", 20'h00000, MAKER);
      rd("part", 20'h00001, PART);
   endtask
   task automatic t_abort();
      req(2'h2, 20'h00020, 16'h0040, 16'h0F0F);
      busy_run();
      i_powerdown = 1'b1;
      repeat (4) @(negedge i_clk);
      chk("pd_pin", 16'h0000, {15'h0, pd_n});
      i_powerdown = 1'b0;
      wake(25);
      rd("wake_array", 20'h00010, 16'h1234);
      req(2'h1, 20'h00000, 16'h0000, 16'h0070);
      rd("wake_status", 20'h00000, 16'h0080);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      i_reset = 1'b1;
      i_req = 1'b0;
      i_op = 2'h0;
      i_addr = 20'h00000;
      i_cmd = 16'h0000;
      i_wdata = 16'h0000;
      i_powerdown = 1'b0;
      err_count = 0;
      samples_checked = 0;
      repeat (6) @(negedge i_clk);
      chk("pd_reset", 16'h0000, {15'h0, pd_n});
      chk("ce_reset", 16'h0001, {15'h0, o_ce_n});
      i_reset = 1'b0;
      wake(15);
      rd("first_read", 20'h00123, 16'hFFFF);
      t_ident();
      t_program();
      t_one_step();
      t_abort();
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ==== tb/flash_dev_model.sv ====
// behavioural flash device on the far side of the host controller
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model
   import flash_host_pkg::*;
#(
   parameter logic [15:0] MAKER = 16'h00A5, // arbitrary value
   parameter logic [15:0] PART = 16'h005A, // arbitrary value
   parameter logic [7:0] C_ID = 8'h90,
   parameter logic [7:0] C_STAT = 8'h70,
   parameter logic [7:0] C_PROG = 8'h40,
   parameter bit BOOT_LOCK = 1'b0,
   parameter int BUSY_CYC = 30
) (
   // clock
   input wire logic i_clk,
   // flash pins
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic i_pd_n,
   input wire logic i_vpp,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_dq_out,
   input wire logic i_dq_oe,
   output logic [DATA_W-1:0] o_dq,
   output logic o_ready_busy_n
);
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   logic [1:0] mode = 2'h0;
   logic armed = 1'b0;
   logic aborted = 1'b0;
   int busy = 0;
   wire wr = !i_ce_n && !i_we_n;
   initial o_dq = 16'h0000;
   assign o_ready_busy_n = !(busy > 0 || (aborted && !i_pd_n));
   function automatic logic [15:0] drv();
      case (mode)
         2'h1: return i_addr[0] ? PART : MAKER;
         2'h2: return {8'h00, busy == 0, 7'h00};
         default: return mem.exists(i_addr) ? mem[i_addr] : 16'hFFFF;
      endcase
   endfunction
   // first strobe to rise latches address and data
   always @(negedge wr) begin
      if (i_pd_n && armed) begin
         armed = 1'b0;
         mode = 2'h2;
         if (i_vpp && busy == 0 && !(BOOT_LOCK && i_addr < 20'h02000)) begin
            mem[i_addr] = i_dq_out;
            busy = BUSY_CYC;
         end
      end else if (i_pd_n) begin
         armed = (i_dq_out[7:0] == C_PROG);
         mode = (i_dq_out[7:0] == C_ID) ? 2'h1 :
            (i_dq_out[7:0] == C_STAT || armed) ? 2'h2 : 2'h0;
      end
   end
   always @(negedge i_pd_n) begin
      aborted = (busy > 0);
      busy = 0;
      armed = 1'b0;
   end
   always @(posedge i_pd_n) begin
      aborted = 1'b0;
      mode = 2'h0;
   end
   // busy counts down off the host's sampling edge to avoid a race
   always @(negedge i_clk) begin
      if (busy > 0) busy = busy - 1;
      if (!i_ce_n && !i_oe_n && i_pd_n) begin
         o_dq <= drv();
      end else if (i_dq_oe) begin
         o_dq <= i_dq_out;
      end else begin
         o_dq <= ~o_dq;
      end
   end
endmodule
`default_nettype wire
